// [rtl/led_dim_pkg.sv]
// Package of constants and types for the LED dimming and pump mode control.
// Assumes a single 25 MHz clock; times are converted to cycle counts here.
package led_dim_pkg;

	// ============================================================
	// Clock and timing
	localparam int unsigned CLK_HZ              = 25000000;
	localparam int unsigned SHUTDOWN_LOW_TIME_US = 1500;
	localparam int unsigned PUMP_DELAY_US        = 400;
	localparam int unsigned PROGRAM_LOW_MIN_NS   = 200;
	localparam int unsigned CLK_PERIOD_NS        = 40;
	// Least times round up
	localparam int unsigned SHUTDOWN_CYCLES = (SHUTDOWN_LOW_TIME_US * (CLK_HZ / 1000000));
	localparam int unsigned PUMP_DELAY_CYCLES = (PUMP_DELAY_US * (CLK_HZ / 1000000));
	localparam int unsigned LOW_FILTER_CYCLES =
		(PROGRAM_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ============================================================
	// Gain and channel layout
	localparam int unsigned NUM_CHANNELS = 4;
	localparam int unsigned GAIN_STEPS   = 6;
	localparam logic [2:0]  GAIN_FULL    = 3'h0;
	localparam logic [2:0]  GAIN_LAST    = 3'h5;

	// ============================================================
	// Pump modes, Gray coded along the climb
	typedef enum logic [1:0] {
		PUMP_1X   = 2'h0,
		PUMP_1X33 = 2'h1,
		PUMP_1X5  = 2'h3,
		PUMP_2X   = 2'h2
	} pump_mode_t;

	// Enable state, Gray coded
	typedef enum logic [1:0] {
		EN_SHUTDOWN = 2'h0,
		EN_ACTIVE   = 2'h1
	} en_state_t;

endpackage

// [rtl/pump_mode_if.sv]
// Interface between the enable control and the pump sequencer.
// Both ends sit on the same clock.
`timescale 1ns/100ps
interface pump_mode_if;
	import led_dim_pkg::*;
	logic       run;        // Device enabled
	logic       starved;    // Some channel cannot regulate
	logic       unity_ok;   // Supply is enough for unity mode
	pump_mode_t mode;       // Current pump mode

	modport ctrl (output run, output starved, output unity_ok, input mode);
	modport seq  (input run, input starved, input unity_ok, output mode);
endinterface

// [rtl/pump_sequencer.sv]
// Charge pump mode sequencer: climbs one mode after a fixed delay, drops to unity.
// Assumes its inputs are already synchronous to clk_in.
`timescale 1ns/100ps
module pump_sequencer #(
	parameter int unsigned DELAY_CYCLES = led_dim_pkg::PUMP_DELAY_CYCLES
) (
	input  wire logic clk_in,
	input  wire logic reset_in,
	pump_mode_if.seq  pm
);
	import led_dim_pkg::*;

	pump_mode_t  mode_q;
	logic [15:0] wait_q;

	assign pm.mode = mode_q;

	// ============================================================
	// Delay counter; restarts whenever the starvation condition lapses
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			wait_q <= 16'h0000;
		end else if (!pm.run || !pm.starved || pm.unity_ok || mode_q == PUMP_2X) begin
			wait_q <= 16'h0000;
		end else if (wait_q == 16'(DELAY_CYCLES - 1)) begin
			wait_q <= 16'h0000;
		end else begin
			wait_q <= wait_q + 16'h0001;
		end
	end

	// ============================================================
	// Mode register; unity always wins so no fractional step down exists
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			mode_q <= PUMP_1X;
		end else if (!pm.run || pm.unity_ok) begin
			mode_q <= PUMP_1X;
		end else if (pm.starved && wait_q == 16'(DELAY_CYCLES - 1)) begin
			case (mode_q)
				PUMP_1X:   mode_q <= PUMP_1X33;
				PUMP_1X33: mode_q <= PUMP_1X5;
				PUMP_1X5:  mode_q <= PUMP_2X;
				default:   mode_q <= PUMP_2X;
			endcase
		end
	end

endmodule

// [rtl/led_dim_ctrl.sv]
// Top of the LED driver control: one-wire enable/dimming decode, gain select,
// shutdown timing, undervoltage lock and pump mode sequencing.
// Assumes the enable/dimming pin and analog comparator flags are asynchronous.
`timescale 1ns/100ps

// Summary of operation
// - Undervoltage forces shutdown and turns every channel off.
// - The first high level after shutdown enables the device at full-scale gain.
// - A low level held for the shutdown time puts the device in zero-current shutdown.
// - In shutdown the channel sinks and current-set pin are released to high impedance.
// - The pump starts in unity mode and stays there while currents regulate.
// - A mode climb happens only after the fixed delay of starvation.
// - Modes climb unity, 1.33, 1.5, 2 and stop at the top.
// - When unity is sufficient the pump goes straight back to unity.
// - Each rising edge while enabled halves the gain from 132 down to 4.125.
// - The sixth pulse restores full scale and pulses keep cycling the six gains.
// - Low pulses shorter than the minimum program low time are filtered out.
module led_dim_ctrl #(
	parameter int unsigned SHUTDOWN_CYCLES  = led_dim_pkg::SHUTDOWN_CYCLES,
	parameter int unsigned PUMP_CYCLES      = led_dim_pkg::PUMP_DELAY_CYCLES,
	parameter int unsigned FILTER_CYCLES    = led_dim_pkg::LOW_FILTER_CYCLES
) (
	input  wire logic                                 CLK_IN,
	input  wire logic                                 RESET_IN,
	input  wire logic                                 EN_DIM_IN,
	input  wire logic                                 UNDERVOLTAGE_IN,
	input  wire logic [led_dim_pkg::NUM_CHANNELS-1:0] CHANNEL_STARVED_IN,
	input  wire logic                                 UNITY_SUFFICIENT_IN,
	output logic                                      ENABLED_OUT,
	output logic [2:0]                                GAIN_STEP_OUT,
	output logic [led_dim_pkg::NUM_CHANNELS-1:0]      LED_SINK_CHANNEL_OE_OUT,
	output logic                                      CURRENT_SET_PIN_OE_OUT,
	output led_dim_pkg::pump_mode_t                   PUMP_MODE_OUT
);
	import led_dim_pkg::*;

	// ============================================================
	// Synchronisers
	logic       en_meta_q;
	logic       en_sync_q;
	logic       en_prev_q;
	logic       uv_meta_q;
	logic       uv_sync_q;
	logic       unity_meta_q;
	logic       unity_sync_q;
	logic [NUM_CHANNELS-1:0] starve_meta_q;
	logic [NUM_CHANNELS-1:0] starve_sync_q;

	// Two flops per asynchronous input; only the second stage feeds logic
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			en_meta_q    <= 1'b0;
			en_sync_q    <= 1'b0;
			uv_meta_q    <= 1'b1;
			uv_sync_q    <= 1'b1;
			unity_meta_q <= 1'b0;
			unity_sync_q <= 1'b0;
		end else begin
			en_meta_q    <= EN_DIM_IN;
			en_sync_q    <= en_meta_q;
			uv_meta_q    <= UNDERVOLTAGE_IN;
			uv_sync_q    <= uv_meta_q;
			unity_meta_q <= UNITY_SUFFICIENT_IN;
			unity_sync_q <= unity_meta_q;
		end
	end

	// Per channel starvation synchronisers
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_starve
			always_ff @(posedge CLK_IN or posedge RESET_IN) begin
				if (RESET_IN) begin
					starve_meta_q[ch] <= 1'b0;
					starve_sync_q[ch] <= 1'b0;
				end else begin
					starve_meta_q[ch] <= CHANNEL_STARVED_IN[ch];
					starve_sync_q[ch] <= starve_meta_q[ch];
				end
			end
		end
	endgenerate

	// Previous synchronised level for edge detection
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			en_prev_q <= 1'b0;
		end else begin
			en_prev_q <= en_sync_q;
		end
	end

	// ============================================================
	// Low time measurement
	logic [15:0] low_cnt_q;
	logic        low_long_q;    // Low lasted past the glitch filter
	logic        rise;
	logic        shutdown_due;

	assign rise         = en_sync_q && !en_prev_q;
	assign shutdown_due = !en_sync_q && (low_cnt_q == 16'(SHUTDOWN_CYCLES - 1));

	// Counts low cycles; any high level restarts it
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			low_cnt_q <= 16'h0000;
		end else if (en_sync_q) begin
			low_cnt_q <= 16'h0000;
		end else if (low_cnt_q != 16'(SHUTDOWN_CYCLES - 1)) begin
			low_cnt_q <= low_cnt_q + 16'h0001;
		end
	end

	// Remembers whether the last low was long enough to count as a pulse
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			low_long_q <= 1'b0;
		end else if (en_sync_q) begin
			if (rise) begin
				low_long_q <= 1'b0;
			end
		end else if (low_cnt_q >= 16'(FILTER_CYCLES - 1)) begin
			low_long_q <= 1'b1;
		end
	end

	// ============================================================
	// Enable state machine
	en_state_t state_q;

	// Undervoltage outranks everything; a long low also drops to shutdown
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			state_q <= EN_SHUTDOWN;
		end else begin
			case (state_q)
				EN_SHUTDOWN: begin
					if (!uv_sync_q && en_sync_q) begin
						state_q <= EN_ACTIVE;
					end
				end
				EN_ACTIVE: begin
					if (uv_sync_q) begin
						state_q <= EN_SHUTDOWN;
					end else if (shutdown_due) begin
						state_q <= EN_SHUTDOWN;
					end
				end
				default: state_q <= EN_SHUTDOWN;
			endcase
		end
	end

	// ============================================================
	// Gain step counter
	logic [2:0] gain_q;

	// Cleared in shutdown so every wake-up starts at full scale
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			gain_q <= GAIN_FULL;
		end else if (state_q != EN_ACTIVE) begin
			gain_q <= GAIN_FULL;
		end else if (rise && low_long_q) begin
			if (gain_q == GAIN_LAST) begin
				gain_q <= GAIN_FULL;
			end else begin
				gain_q <= gain_q + 3'h1;
			end
		end
	end

	// ============================================================
	// Pump sequencer
	pump_mode_if pm ();

	assign pm.run      = (state_q == EN_ACTIVE);
	assign pm.starved  = |starve_sync_q;
	assign pm.unity_ok = unity_sync_q;

	pump_sequencer #(
		.DELAY_CYCLES (PUMP_CYCLES)
	) u_pump (
		.clk_in   (CLK_IN),
		.reset_in (RESET_IN),
		.pm       (pm.seq)
	);

	// ============================================================
	// Output registers; a drop out of the active state releases the pins next edge
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			ENABLED_OUT             <= 1'b0;
			GAIN_STEP_OUT           <= GAIN_FULL;
			LED_SINK_CHANNEL_OE_OUT <= '0;
			CURRENT_SET_PIN_OE_OUT  <= 1'b0;
			PUMP_MODE_OUT           <= PUMP_1X;
		end else begin
			ENABLED_OUT             <= (state_q == EN_ACTIVE);
			GAIN_STEP_OUT           <= gain_q;
			LED_SINK_CHANNEL_OE_OUT <= {NUM_CHANNELS{state_q == EN_ACTIVE}};
			CURRENT_SET_PIN_OE_OUT  <= (state_q == EN_ACTIVE);
			PUMP_MODE_OUT           <= pm.mode;
		end
	end

endmodule

// [testbench/led_dim_chk.sv]
// Port checker for the LED dimming and pump mode control.
// Assumes it is bound to led_dim_ctrl and sees only its ports.
`timescale 1ns/100ps
module led_dim_chk
	import led_dim_pkg::*;
#(
	parameter int unsigned SHUTDOWN_CYCLES = 50,
	parameter int unsigned PUMP_CYCLES     = 20
) (
	input wire logic                                 CLK_IN,
	input wire logic                                 RESET_IN,
	input wire logic                                 EN_DIM_IN,
	input wire logic                                 UNDERVOLTAGE_IN,
	input wire logic [led_dim_pkg::NUM_CHANNELS-1:0] CHANNEL_STARVED_IN,
	input wire logic                                 UNITY_SUFFICIENT_IN,
	input wire logic                                 ENABLED_OUT,
	input wire logic [2:0]                           GAIN_STEP_OUT,
	input wire logic [led_dim_pkg::NUM_CHANNELS-1:0] LED_SINK_CHANNEL_OE_OUT,
	input wire logic                                 CURRENT_SET_PIN_OE_OUT,
	input wire led_dim_pkg::pump_mode_t              PUMP_MODE_OUT
);
	// ============================================================
	// Helper counters
	logic [15:0] low_run_q;
	logic [15:0] since_q;
	pump_mode_t  last_q;

	// Low run of the pin; saturates so a long shutdown never wraps
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			low_run_q <= '0;
		end else if (EN_DIM_IN) begin
			low_run_q <= '0;
		end else if (low_run_q != 16'hffff) begin
			low_run_q <= low_run_q + 16'h1;
		end
	end

	// Cycles since the pump mode last moved
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			since_q <= '0;
			last_q  <= PUMP_1X;
		end else begin
			last_q  <= PUMP_MODE_OUT;
			since_q <= (PUMP_MODE_OUT != last_q) ? 16'h0 : since_q + {15'h0, since_q != 16'hffff};
		end
	end

	// ============================================================
	// Assertions
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RESET_IN);
	sequence s_uv_held;
		UNDERVOLTAGE_IN [*3];
	endsequence
	sequence s_unity_held;
		UNITY_SUFFICIENT_IN [*6];
	endsequence
	a_uv_forces_off: assert property (s_uv_held |-> ##[0:3] !ENABLED_OUT)
		else $error("enabled during undervoltage");
	a_enable_full_gain: assert property ($rose(ENABLED_OUT) |-> $past(EN_DIM_IN, 4) && GAIN_STEP_OUT == GAIN_FULL)
		else $error("bad enable");
	a_shutdown_low_time: assert property ($fell(ENABLED_OUT) |-> UNDERVOLTAGE_IN || low_run_q >= 16'(SHUTDOWN_CYCLES))
		else $error("shutdown too early");
	a_pins_follow_enable: assert property (LED_SINK_CHANNEL_OE_OUT == {NUM_CHANNELS{ENABLED_OUT}}
		&& CURRENT_SET_PIN_OE_OUT == ENABLED_OUT)
		else $error("pin enables disagree with state");
	a_idle_unity_mode: assert property ((!ENABLED_OUT) [*3] |-> PUMP_MODE_OUT == PUMP_1X)
		else $error("pump not unity while off");
	a_pump_climb_wait: assert property (PUMP_MODE_OUT != last_q && PUMP_MODE_OUT != PUMP_1X
		|-> since_q + 16'h1 >= 16'(PUMP_CYCLES))
		else $error("pump climbed early");
	a_pump_order_kept: assert property ($changed(PUMP_MODE_OUT) |-> PUMP_MODE_OUT == PUMP_1X
		|| ($past(PUMP_MODE_OUT) == PUMP_1X && PUMP_MODE_OUT == PUMP_1X33)
		|| ($past(PUMP_MODE_OUT) == PUMP_1X33 && PUMP_MODE_OUT == PUMP_1X5)
		|| ($past(PUMP_MODE_OUT) == PUMP_1X5 && PUMP_MODE_OUT == PUMP_2X))
		else $error("pump mode out of order");
	a_unity_return: assert property (s_unity_held |-> PUMP_MODE_OUT == PUMP_1X)
		else $error("pump not back at unity");
	a_gain_halving: assert property (ENABLED_OUT && $past(ENABLED_OUT) && $changed(GAIN_STEP_OUT)
		|-> GAIN_STEP_OUT == (($past(GAIN_STEP_OUT) == GAIN_LAST) ? GAIN_FULL : $past(GAIN_STEP_OUT) + 3'h1))
		else $error("gain step skipped");
endmodule

bind led_dim_ctrl led_dim_chk #(.SHUTDOWN_CYCLES(SHUTDOWN_CYCLES), .PUMP_CYCLES(PUMP_CYCLES)) chk_i (
	.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .EN_DIM_IN(EN_DIM_IN), .UNDERVOLTAGE_IN(UNDERVOLTAGE_IN),
	.CHANNEL_STARVED_IN(CHANNEL_STARVED_IN), .UNITY_SUFFICIENT_IN(UNITY_SUFFICIENT_IN),
	.ENABLED_OUT(ENABLED_OUT), .GAIN_STEP_OUT(GAIN_STEP_OUT), .LED_SINK_CHANNEL_OE_OUT(LED_SINK_CHANNEL_OE_OUT),
	.CURRENT_SET_PIN_OE_OUT(CURRENT_SET_PIN_OE_OUT), .PUMP_MODE_OUT(PUMP_MODE_OUT));

// [testbench/dim_host.sv]
// Host model pulsing the one-wire enable/dimming pin.
// Assumes a 25 MHz clock; levels change just after a falling edge.
`timescale 1ns/100ps
module dim_host (
	input  wire logic clk_in,
	output logic      en_dim_out
);
	// Pin starts low, as its pull-down would leave it
	initial en_dim_out = 1'b0;

	// Hold one level for n cycles
	task automatic drive(input logic lvl, input int n);
		@(negedge clk_in);
		en_dim_out = lvl;
		repeat (n - 1) @(negedge clk_in);
	endtask

	// Dimming pulse; a low under 5 cycles is only sent on purpose
	task automatic pulse(input int lo, input int hi);
		drive(1'b0, lo);
		drive(1'b1, hi);
	endtask

	// Enable and wait past the setup time (250 cycles) before dimming
	task automatic wake();
		drive(1'b1, 260);
	endtask
endmodule

// [testbench/led_dim_pulse_mode_control_tb.sv]
// Self-checking bench for the LED dimming and pump mode control.
// Assumes the checker binds itself; shortened counts keep the run brief.
`timescale 1ns/100ps
module led_dim_pulse_mode_control_tb;
	import led_dim_pkg::*;
	localparam int unsigned SD = 50;
	localparam int unsigned PC = 20;
	logic                    clk_in = 1'b0;
	logic                    reset_in = 1'b1;
	logic                    uv_in = 1'b0;
	logic                    unity_in = 1'b0;
	logic [NUM_CHANNELS-1:0] starved_in = '0;
	logic                    en_dim;
	logic                    enabled;
	logic [2:0]              gain;
	logic [NUM_CHANNELS-1:0] led_oe;
	logic                    current_set_oe;
	pump_mode_t              mode;
	int                      failures = 0;
	int                      tests_run = 0;

	// ============================================================
	// Clock, host and design
	always #20 clk_in = ~clk_in;
	dim_host host (.clk_in(clk_in), .en_dim_out(en_dim));
	led_dim_ctrl #(.SHUTDOWN_CYCLES(SD), .PUMP_CYCLES(PC), .FILTER_CYCLES(5)) uut (.CLK_IN(clk_in),
		.RESET_IN(reset_in), .EN_DIM_IN(en_dim), .UNDERVOLTAGE_IN(uv_in), .CHANNEL_STARVED_IN(starved_in),
		.UNITY_SUFFICIENT_IN(unity_in), .ENABLED_OUT(enabled), .GAIN_STEP_OUT(gain),
		.LED_SINK_CHANNEL_OE_OUT(led_oe), .CURRENT_SET_PIN_OE_OUT(current_set_oe), .PUMP_MODE_OUT(mode));

	// ============================================================
	// Shared tasks
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Bounded wait for a pump mode; running out ends the run
	task automatic wait_mode(input pump_mode_t exp, input int limit);
		for (int i = 0; i < limit; i++) begin
			@(negedge clk_in);
			if (mode === exp) return;
		end
		failures++;
		$display("CHECK FAILED pump mode expected %h seen %h", exp, mode);
		final_report();
	endtask

	// ============================================================
	// Scenarios
	task automatic t_enable();
		chk("sinks off", 4'h0, led_oe);
		host.wake();
		chk("enabled", 4'h1, {3'h0, enabled});
		chk("gain", 4'h0, {1'b0, gain});
		chk("sinks on", 4'hf, led_oe);
		chk("pump", 4'h0, {2'h0, mode});
		$display("enable test done");
	endtask
	// Seven minimum-width pulses walk the gains and wrap once
	task automatic t_dim();
		for (int i = 1; i <= 7; i++) begin
			host.pulse(5, 6);
			chk("gain", 4'(i % 6), {1'b0, gain});
		end
		$display("dimming test done");
	endtask
	// A 4-cycle low is too short to count
	task automatic t_filter();
		host.pulse(4, 6);
		chk("gain", 4'h1, {1'b0, gain});
		host.pulse(5, 6);
		chk("gain", 4'h2, {1'b0, gain});
		$display("filter test done");
	endtask
	task automatic t_pump();
		starved_in = 4'h4;
		wait_mode(PUMP_1X33, PC + 20);
		repeat (PC - 5) @(negedge clk_in);
		chk("pump hold", 4'h1, {2'h0, mode});
		wait_mode(PUMP_1X5, PC + 20);
		wait_mode(PUMP_2X, PC + 20);
		repeat (2 * PC) @(negedge clk_in);
		chk("pump top", 4'h2, {2'h0, mode});
		starved_in = 4'h0;
		unity_in = 1'b1;
		wait_mode(PUMP_1X, 8);
		unity_in = 1'b0;
		$display("pump test done");
	endtask
	task automatic t_shutdown();
		host.pulse(SD - 10, 8);
		chk("still on", 4'h1, {3'h0, enabled});
		host.drive(1'b0, SD + 8);
		chk("off", 4'h0, {3'h0, enabled});
		chk("sinks off", 4'h0, {led_oe[3:1], current_set_oe});
		host.wake();
		chk("gain", 4'h0, {1'b0, gain});
		$display("shutdown test done");
	endtask
	task automatic t_uv();
		uv_in = 1'b1;
		repeat (8) @(negedge clk_in);
		chk("off", 4'h0, {3'h0, enabled});
		chk("sinks off", 4'h0, led_oe);
		uv_in = 1'b0;
		$display("undervoltage test done");
	endtask

	// ============================================================
	// Main sequence
	initial begin
		repeat (5) @(negedge clk_in);
		reset_in = 1'b0;
		t_enable();
		t_dim();
		t_filter();
		t_pump();
		t_shutdown();
		t_uv();
		final_report();
	end
endmodule
